//--- pkg/mrs_pkg.sv
package mrs_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int BAUD = 19200;
  localparam int BIT_CYC = CLK_HZ / BAUD;
  localparam logic [11:0] BIT_LOAD = 12'(BIT_CYC - 1);
  localparam logic [11:0] HALF_LOAD = 12'(BIT_CYC / 2 - 1);
  localparam int DATA_BITS = 8;
  localparam logic [2:0] LAST_BIT = 3'(DATA_BITS - 1);
  localparam int GAP_MS = 20;
  localparam int GAP_CYC = GAP_MS * (CLK_HZ / 1000);
  localparam int REQ_BYTES = 8;
  localparam logic [3:0] LAST_REQ = 4'(REQ_BYTES - 1);
  localparam logic [7:0] FUNC_READ = 8'h03;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [7:0] MAX_REGS = 8'h10;
  localparam logic [7:0] HDR_BYTES = 8'h03;
  // Register map, zero-based indices
  localparam logic [15:0] REG_RSVD0 = 16'h0000;
  localparam logic [15:0] REG_RSVD_VAL = 16'h0000;
  localparam logic [15:0] REG_EPOCH_HI = 16'h0004;
  localparam logic [15:0] REG_EPOCH_LO = 16'h0005;
  localparam logic [15:0] REG_RPM = 16'h0006;
  localparam logic [15:0] REG_DIR = 16'h0007;
  localparam logic [15:0] REG_CURRENT = 16'h0008;
  localparam logic [15:0] REG_INDICATOR = 16'h0009;

  function automatic logic [15:0] crc_step(input logic [15:0] crc,
                                           input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction
endpackage

//--- logic/mrs_slave.sv
// Functional notes
// - Characters are 8N1 at 19200 baud with no flow control.
// - The block is a slave only and answers frames to its station address.
// - Read holding registers, function 3, is the supported request.
// - A reply is address, function 3, byte count, a word per register, CRC.
// - A well formed request to this station for 1 to 16 registers, received while the transmitter is idle, is answered with register data.
// - Register addresses are zero-based indices, the first entry at 0.
// - The map exposes motor speed, direction, current and indicator status.
// - Data comes in on the receive line and goes out on the transmit line.
// - Date and time is an epoch count split into high and low words.
`timescale 1ns/1ps
`default_nettype none
module mrs_slave
  import mrs_pkg::*;
#(
  parameter int GAP_CYCLES = GAP_CYC,
  parameter int BIT_CYCLES = BIT_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Serial link
  input wire logic rxd,
  output logic txd,
  // Station address, held stable by the controller
  input wire logic [7:0] station_addr,
  // Status words
  input wire logic [15:0] motor_rpm,
  input wire logic [15:0] motor_dir,
  input wire logic [15:0] motor_current,
  input wire logic [15:0] indicator_status,
  input wire logic [15:0] epoch_high,
  input wire logic [15:0] epoch_low
);
  typedef enum logic [1:0] {S_IDLE, S_START, S_DATA, S_STOP} mrs_ser_t;

  // Bit timing follows the parameter so that a bench may run the link faster
  localparam logic [11:0] BIT_LD = 12'(BIT_CYCLES - 1);
  localparam logic [11:0] HALF_LD = 12'(BIT_CYCLES / 2 - 1);

  // Receive side
  logic rx_s1, rx_s2, rx_s3, rx_line, next_rx_line;
  mrs_ser_t rx_st, next_rx_st;
  logic [11:0] rcnt, next_rcnt;
  logic [2:0] rbit, next_rbit;
  logic [7:0] rsh, next_rsh;
  logic byte_stb, rx_bad;

  always_comb begin
    next_rx_line = (rx_s2 == rx_s3) ? rx_s3 : rx_line;
    next_rx_st = rx_st;
    next_rcnt = (rcnt != 12'h000) ? rcnt - 12'h001 : rcnt;
    next_rbit = rbit;
    next_rsh = rsh;
    byte_stb = 1'b0;
    rx_bad = 1'b0;
    case (rx_st)
      S_IDLE: begin
        if (!rx_line) begin
          next_rx_st = S_START;
          next_rcnt = HALF_LD;
        end
      end
      S_START: begin
        if (rcnt == 12'h000) begin
          // A glitch shorter than half a bit is not a start bit
          next_rx_st = rx_line ? S_IDLE : S_DATA;
          next_rcnt = BIT_LD;
          next_rbit = 3'h0;
        end
      end
      S_DATA: begin
        if (rcnt == 12'h000) begin
          next_rsh = {rx_line, rsh[7:1]};
          next_rcnt = BIT_LD;
          next_rbit = rbit + 3'h1;
          if (rbit == LAST_BIT) begin
            next_rx_st = S_STOP;
          end
        end
      end
      S_STOP: begin
        if (rcnt == 12'h000) begin
          byte_stb = rx_line;
          rx_bad = !rx_line;
          next_rx_st = S_IDLE;
        end
      end
      default: next_rx_st = S_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_s3 <= 1'b1;
      rx_line <= 1'b1;
      rx_st <= S_IDLE;
      rcnt <= 12'h000;
      rbit <= 3'h0;
      rsh <= 8'h00;
    end else begin
      rx_s1 <= rxd;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      rx_line <= next_rx_line;
      rx_st <= next_rx_st;
      rcnt <= next_rcnt;
      rbit <= next_rbit;
      rsh <= next_rsh;
    end
  end

  // Frame assembly
  logic [7:0] rbuf [0:REQ_BYTES-1];
  logic [3:0] nbytes, next_nbytes;
  logic [15:0] rcrc, next_rcrc, crc_in;
  logic [19:0] gap, next_gap;
  logic [15:0] req_start, next_req_start;
  logic [7:0] req_cnt, next_req_cnt;
  logic [15:0] cnt_word;
  logic go, frame_ok;
  mrs_ser_t tx_st;

  assign crc_in = crc_step(rcrc, rsh);
  assign cnt_word = {rbuf[4], rbuf[5]};
  // Trailing CRC folded into the running CRC leaves zero when intact
  assign frame_ok = (crc_in == 16'h0000) &&
                    (rbuf[0] == station_addr) &&
                    (rbuf[1] == FUNC_READ) &&
                    (cnt_word != 16'h0000) &&
                    (cnt_word <= {8'h00, MAX_REGS});
  assign go = byte_stb && (nbytes == LAST_REQ) && frame_ok &&
              (tx_st == S_IDLE);

  always_comb begin
    next_nbytes = nbytes;
    next_rcrc = rcrc;
    next_gap = gap;
    next_req_start = req_start;
    next_req_cnt = req_cnt;
    if (byte_stb) begin
      next_gap = 20'h00000;
      next_rcrc = crc_in;
      next_nbytes = nbytes + 4'h1;
      if (nbytes == LAST_REQ) begin
        // Fixed-length request, so decode on the last byte
        next_nbytes = 4'h0;
        next_rcrc = CRC_INIT;
        if (go) begin
          next_req_start = {rbuf[2], rbuf[3]};
          next_req_cnt = rbuf[5];
        end
      end
    end else if (rx_bad || gap >= 20'(GAP_CYCLES)) begin
      // A silent line longer than the byte gap ends any partial frame
      next_nbytes = 4'h0;
      next_rcrc = CRC_INIT;
    end
    if (!byte_stb && rx_st == S_IDLE && gap < 20'(GAP_CYCLES)) begin
      next_gap = gap + 20'h00001;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      nbytes <= 4'h0;
      rcrc <= CRC_INIT;
      gap <= 20'h00000;
      req_start <= 16'h0000;
      req_cnt <= 8'h00;
    end else begin
      nbytes <= next_nbytes;
      rcrc <= next_rcrc;
      gap <= next_gap;
      req_start <= next_req_start;
      req_cnt <= next_req_cnt;
    end
  end

  always_ff @(posedge clock) begin
    if (byte_stb && nbytes != LAST_REQ) begin
      rbuf[nbytes[2:0]] <= rsh;
    end
  end

  // Transmit side
  mrs_ser_t next_tx_st;
  logic [11:0] tcnt, next_tcnt;
  logic [2:0] tbit, next_tbit;
  logic [7:0] tsh, next_tsh, tk, next_tk, total, cur_byte, ld_k, ld_cnt;
  logic [15:0] tcrc, next_tcrc, ld_crc, ridx, rword;
  logic next_txd;

  assign ld_k = (tx_st == S_IDLE) ? 8'h00 : tk + 8'h01;
  assign ld_cnt = (tx_st == S_IDLE) ? rbuf[5] : req_cnt;
  assign ld_crc = (tx_st == S_IDLE) ? CRC_INIT : tcrc;
  assign total = 8'(HDR_BYTES + 8'h02 + {ld_cnt[6:0], 1'b0});
  assign ridx = ((tx_st == S_IDLE) ? {rbuf[2], rbuf[3]} : req_start)
                + {9'h000, 7'((ld_k - HDR_BYTES) >> 1)};

  always_comb begin
    case (ridx)
      REG_RSVD0: rword = REG_RSVD_VAL;
      REG_EPOCH_HI: rword = epoch_high;
      REG_EPOCH_LO: rword = epoch_low;
      REG_RPM: rword = motor_rpm;
      REG_DIR: rword = motor_dir;
      REG_CURRENT: rword = motor_current;
      REG_INDICATOR: rword = indicator_status;
      default: rword = 16'h0000;
    endcase
  end

  always_comb begin
    if (ld_k == 8'h00) begin
      cur_byte = station_addr;
    end else if (ld_k == 8'h01) begin
      cur_byte = FUNC_READ;
    end else if (ld_k == 8'h02) begin
      cur_byte = {ld_cnt[6:0], 1'b0};
    end else if (ld_k < total - 8'h02) begin
      cur_byte = ld_k[0] ? rword[15:8] : rword[7:0];
    end else if (ld_k == total - 8'h02) begin
      cur_byte = ld_crc[7:0];
    end else begin
      cur_byte = ld_crc[15:8];
    end
  end

  always_comb begin
    next_tx_st = tx_st;
    next_tcnt = (tcnt != 12'h000) ? tcnt - 12'h001 : tcnt;
    next_tbit = tbit;
    next_tsh = tsh;
    next_tk = tk;
    next_tcrc = tcrc;
    next_txd = txd;
    case (tx_st)
      S_IDLE: begin
        next_txd = 1'b1;
        if (go) begin
          next_tx_st = S_START;
          next_tsh = cur_byte;
          next_tk = 8'h00;
          next_tcrc = crc_step(CRC_INIT, cur_byte);
          next_tcnt = BIT_LD;
          next_txd = 1'b0;
        end
      end
      S_START: begin
        if (tcnt == 12'h000) begin
          next_tx_st = S_DATA;
          next_tcnt = BIT_LD;
          next_tbit = 3'h0;
          next_txd = tsh[0];
        end
      end
      S_DATA: begin
        if (tcnt == 12'h000) begin
          next_tcnt = BIT_LD;
          next_tbit = tbit + 3'h1;
          next_tsh = {1'b1, tsh[7:1]};
          next_txd = tsh[1];
          if (tbit == LAST_BIT) begin
            next_tx_st = S_STOP;
            next_txd = 1'b1;
          end
        end
      end
      S_STOP: begin
        if (tcnt == 12'h000) begin
          if (tk == total - 8'h01) begin
            next_tx_st = S_IDLE;
          end else begin
            next_tx_st = S_START;
            next_tk = ld_k;
            next_tsh = cur_byte;
            next_tcnt = BIT_LD;
            next_txd = 1'b0;
            if (ld_k < total - 8'h02) begin
              next_tcrc = crc_step(tcrc, cur_byte);
            end
          end
        end
      end
      default: next_tx_st = S_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tx_st <= S_IDLE;
      tcnt <= 12'h000;
      tbit <= 3'h0;
      tsh <= 8'h00;
      tk <= 8'h00;
      tcrc <= CRC_INIT;
      txd <= 1'b1;
    end else begin
      tx_st <= next_tx_st;
      tcnt <= next_tcnt;
      tbit <= next_tbit;
      tsh <= next_tsh;
      tk <= next_tk;
      tcrc <= next_tcrc;
      txd <= next_txd;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_enter_start;
    tx_st == S_START && $past(tx_st) != S_START;
  endsequence

  rx_filter_a: assert property (rx_line != $past(rx_line) |->
    $past(rx_s2) == $past(rx_s3)) else $error("rx level unfiltered");
  tx_idle_a: assert property (tx_st == S_IDLE &&
    $past(tx_st) == S_IDLE |-> txd) else $error("line not idle high");
  start_low_a: assert property (tx_st == S_START |-> !txd)
    else $error("start bit not low");
  stop_high_a: assert property (tx_st == S_STOP |-> txd)
    else $error("stop bit not high");
  bit_len_a: assert property (s_enter_start |-> tcnt == BIT_LD ##1
    (tx_st == S_START && tcnt == BIT_LD - 12'h001))
    else $error("bit time wrong");
  reply_addr_a: assert property (go |=> s_enter_start and
    (tsh == $past(station_addr) && tk == 8'h00))
    else $error("reply address wrong");
  reply_func_a: assert property (s_enter_start and tk == 8'h01 |->
    tsh == FUNC_READ) else $error("reply function wrong");
  bad_crc_a: assert property (byte_stb && nbytes == LAST_REQ &&
    crc_in != 16'h0000 && tx_st == S_IDLE |=> tx_st == S_IDLE [*2])
    else $error("bad crc answered");
  foreign_addr_a: assert property (byte_stb && nbytes == LAST_REQ &&
    rbuf[0] != station_addr && tx_st == S_IDLE |=> tx_st == S_IDLE)
    else $error("foreign frame answered");
  gap_reset_a: assert property (!byte_stb &&
    gap >= 20'(GAP_CYCLES) |=> nbytes == 4'h0) else $error("stale frame kept");
endmodule
`default_nettype wire

//--- dv/mrs_master.sv
`timescale 1ns/1ps
`default_nettype none
module mrs_master
  import mrs_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYC
) (
  // Clock
  input wire logic clock,
  // Link, seen from the master side
  input wire logic txd,
  output logic rxd
);
  logic [7:0] rx_q[$];
  int stop_errs;

  // Line idles at mark level between characters
  initial begin
    rxd = 1'b1;
    stop_errs = 0;
  end

  // Characters go out back to back, far inside the inter-byte limit
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clock);
      rxd = fr[i];
      repeat (BIT_CYCLES - 1) @(negedge clock);
    end
  endtask

  // Receiver samples mid-bit, LSB first, and checks the stop bit
  always begin
    logic [7:0] b;
    @(negedge clock);
    if (txd === 1'b0) begin
      repeat (BIT_CYCLES / 2) @(negedge clock);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYCLES) @(negedge clock);
        b[i] = txd;
      end
      repeat (BIT_CYCLES) @(negedge clock);
      if (txd !== 1'b1) stop_errs++;
      rx_q.push_back(b);
    end
  end
endmodule
`default_nettype wire

//--- dv/mrs_slave_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mrs_slave_tb_top;
  import mrs_pkg::*;
  // Link runs far faster than 19200 baud here to keep the run short
  localparam int LINK_BIT = 40;
  localparam int GAP = 1000;
  localparam int CHAR = 10 * LINK_BIT;
  // Quiet time before each poll, scaled like the byte gap
  localparam int CMD_GAP = 3 * GAP;
  logic clock, nrst, rxd, txd;
  logic [7:0] station_addr;
  logic [15:0] motor_rpm, motor_dir, motor_current, indicator_status;
  logic [15:0] epoch_high, epoch_low;
  int fail_count, compares;

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  mrs_slave #(.GAP_CYCLES(GAP), .BIT_CYCLES(LINK_BIT)) dut_u (
    .clock(clock), .nrst(nrst), .rxd(rxd), .txd(txd),
    .station_addr(station_addr), .motor_rpm(motor_rpm),
    .motor_dir(motor_dir), .motor_current(motor_current),
    .indicator_status(indicator_status), .epoch_high(epoch_high),
    .epoch_low(epoch_low)
  );

  mrs_master #(.BIT_CYCLES(LINK_BIT)) master_u (
    .clock(clock), .txd(txd), .rxd(rxd)
  );

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  function automatic logic [15:0] reg_val(input logic [15:0] r);
    case (r)
      16'h0004: return epoch_high;
      16'h0005: return epoch_low;
      16'h0006: return motor_rpm;
      16'h0007: return motor_dir;
      16'h0008: return motor_current;
      16'h0009: return indicator_status;
      default: return 16'h0000;
    endcase
  endfunction

  task automatic complete_run;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] got, exp, input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One poll; the next one only starts after the reply or silence window
  task automatic xact(input logic [7:0] a, f, input logic [15:0] st, cnt,
                      input logic [7:0] flip, input bit answer);
    logic [7:0] req[$];
    logic [7:0] exp[$];
    logic [15:0] c, v;
    int n, lim;
    req = {a, f, st[15:8], st[7:0], cnt[15:8], cnt[7:0]};
    c = crc16(req);
    req.push_back(c[7:0] ^ flip);
    req.push_back(c[15:8]);
    master_u.rx_q.delete();
    if (answer) begin
      exp = {a, 8'h03, 8'(2 * cnt)};
      for (int r = 0; r < cnt; r++) begin
        v = reg_val(16'(st + r));
        exp.push_back(v[15:8]);
        exp.push_back(v[7:0]);
      end
      c = crc16(exp);
      exp.push_back(c[7:0]);
      exp.push_back(c[15:8]);
    end
    repeat (CMD_GAP) @(negedge clock);
    foreach (req[i]) master_u.send_byte(req[i]);
    lim = GAP + exp.size() * CHAR;
    n = 0;
    while (n < lim &&
           (exp.size() == 0 || master_u.rx_q.size() < exp.size())) begin
      @(negedge clock);
      n++;
    end
    if (n == lim && exp.size() > 0) begin
      fail_count++;
      $display("[ERR] %0t reply timed out", $time);
      complete_run();
    end
    repeat (2 * LINK_BIT) @(negedge clock);
    cmp8(8'(master_u.rx_q.size()), 8'(exp.size()), "reply length");
    foreach (exp[i])
      if (i < master_u.rx_q.size())
        cmp8(master_u.rx_q[i], exp[i], "reply byte");
    cmp8(8'(master_u.stop_errs), 8'h00, "stop bit");
    cmp8({7'h00, txd}, 8'h01, "idle line");
  endtask

  initial begin
    repeat (90000) @(posedge clock);
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end

  initial begin
    nrst = 1'b0;
    station_addr = 8'h2a;
    motor_rpm = 16'h05dc;
    motor_dir = 16'h0001;
    motor_current = 16'h0123;
    indicator_status = 16'h0005;
    epoch_high = 16'h6512;
    epoch_low = 16'h3abc;
    fail_count = 0;
    compares = 0;
    repeat (5) @(negedge clock);
    nrst = 1'b1;
    repeat (10) @(negedge clock);
    xact(8'h2a, 8'h03, 16'h0004, 16'h0006, 8'h00, 1'b1);
    xact(8'h2a, 8'h03, 16'h0000, 16'h0001, 8'h00, 1'b1);
    xact(8'h2b, 8'h03, 16'h0006, 16'h0001, 8'h00, 1'b0);
    xact(8'h2a, 8'h03, 16'h0006, 16'h0001, 8'h01, 1'b0);
    xact(8'h2a, 8'h04, 16'h0006, 16'h0001, 8'h00, 1'b0);
    xact(8'h2a, 8'h03, 16'h0006, 16'h0000, 8'h00, 1'b0);
    xact(8'h2a, 8'h03, 16'h0000, 16'h0011, 8'h00, 1'b0);
    station_addr = 8'h07;
    motor_rpm = 16'h0abc;
    // A cut frame must be dropped after the byte gap, or the next poll fails
    master_u.send_byte(8'h07);
    master_u.send_byte(8'h03);
    xact(8'h07, 8'h03, 16'h0006, 16'h0002, 8'h00, 1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
